// ### hdl/ptc_pkg.sv
// Package: register map, field layout, reset values and encodings of the pairable timer
package ptc_pkg;

	// ***************************************************************
	// Register map (byte addresses on the bus)
	// ***************************************************************
	localparam logic [11:0] PTC_ADDR_CTRL = 12'h000;
	localparam logic [11:0] PTC_ADDR_LOW = 12'h004;
	localparam logic [11:0] PTC_ADDR_HIGH = 12'h008;
	localparam logic [11:0] PTC_ADDR_PARTNER = 12'h00C;

	// ***************************************************************
	// Control register field positions
	// ***************************************************************
	localparam int PTC_BIT_RUN = 15;
	localparam int PTC_BIT_IDLE_STOP = 13;
	localparam int PTC_BIT_GATE = 6;
	localparam int PTC_BIT_PRESC_LO = 4;
	localparam int PTC_BIT_WIDE = 3;
	localparam int PTC_BIT_SRC = 1;
	localparam int PTC_BIT_PARTNER_RUN = 15;
	localparam logic [15:0] PTC_CTRL_WMASK = 16'hA07A;
	localparam logic [15:0] PTC_PARTNER_WMASK = 16'h8000;

	// ***************************************************************
	// Reset values and encodings
	// ***************************************************************
	localparam logic [15:0] PTC_CTRL_RESET = 16'h0000;
	localparam logic [15:0] PTC_COUNT_RESET = 16'h0000;
	localparam logic [15:0] PTC_COUNT_MAX = 16'hFFFF;
	localparam logic [1:0] PTC_HTRANS_NONSEQ = 2'h2;
	localparam logic [7:0] PTC_DIV_1_LAST = 8'h00;
	localparam logic [7:0] PTC_DIV_8_LAST = 8'h07;
	localparam logic [7:0] PTC_DIV_64_LAST = 8'h3F;
	localparam logic [7:0] PTC_DIV_256_LAST = 8'hFF;

	typedef enum logic [1:0] {
		PTC_PRE_1 = 2'h0,
		PTC_PRE_8 = 2'h1,
		PTC_PRE_64 = 2'h2,
		PTC_PRE_256 = 2'h3
	} ptc_presc_t;

	typedef struct packed {
		logic run;
		logic idle_stop;
		logic gate;
		ptc_presc_t presc;
		logic wide;
		logic src;
	} ptc_ctrl_t;

	// Last prescaler count before a tick passes, per select code
	function automatic logic [7:0] ptc_div_last(input ptc_presc_t code);
		unique case (code)
			PTC_PRE_1: ptc_div_last = PTC_DIV_1_LAST;
			PTC_PRE_8: ptc_div_last = PTC_DIV_8_LAST;
			PTC_PRE_64: ptc_div_last = PTC_DIV_64_LAST;
			PTC_PRE_256: ptc_div_last = PTC_DIV_256_LAST;
		endcase
	endfunction

endpackage

// ### hdl/ptc_tick_if.sv
// Interface: tick path between the timer core and its input prescaler
`timescale 1ns/1ps
`default_nettype none
interface ptc_tick_if;
	import ptc_pkg::*;
	logic tick_in;
	logic clr;
	ptc_presc_t code;
	logic tick_out;
	modport core (output tick_in, output clr, output code, input tick_out);
	modport presc (input tick_in, input clr, input code, output tick_out);
endinterface
`default_nettype wire

// ### hdl/ptc_prescaler.sv
// Module: input clock prescaler dividing gated ticks by 1, 8, 64 or 256
`timescale 1ns/1ps
`default_nettype none
module ptc_prescaler (
	input wire logic clk,
	input wire logic rst,
	ptc_tick_if.presc tk
);
	import ptc_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
	} ptc_pre_state_t;

	ptc_pre_state_t s_r;
	ptc_pre_state_t s_nxt;
	logic at_last;

	// ***************************************************************
	// Divider
	// ***************************************************************

	// Tick passes on the last count; a clear restarts the division cleanly
	assign at_last = (s_r.cnt == ptc_div_last(tk.code));
	assign tk.tick_out = tk.tick_in && at_last && !tk.clr;

	always_comb begin
		s_nxt = s_r;
		if (tk.clr) begin
			s_nxt.cnt = 8'h00;
		end else if (tk.tick_in) begin
			s_nxt.cnt = at_last ? 8'h00 : s_r.cnt + 8'h01;
		end
	end

	// State register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_div8_run7;
		(tk.tick_in && !tk.clr && tk.code == PTC_PRE_8)[*7];
	endsequence

	// A ratio change clears the divider, so only a steady 1:8 must stay quiet
	sequence s_div8_quiet7;
		(!tk.tick_out || tk.code != PTC_PRE_8)[*7];
	endsequence

	chk_div1_every_tick: assert property (
		(tk.tick_in && !tk.clr && tk.code == PTC_PRE_1) |-> tk.tick_out)
		else $error("divide by 1 dropped a tick");
	chk_div8_quiet_gap: assert property (
		(tk.tick_out && tk.code == PTC_PRE_8) |=> s_div8_quiet7)
		else $error("divide by 8 ticked early");
	chk_div8_eighth: assert property (
		(tk.tick_out && tk.code == PTC_PRE_8) ##1 s_div8_run7 ##1
		(tk.tick_in && !tk.clr && tk.code == PTC_PRE_8) |-> tk.tick_out)
		else $error("divide by 8 missed the eighth tick");
endmodule
`default_nettype wire

// ### hdl/ptc_timer.sv
// Module: pairable 16-bit timer with control register, AHB-Lite slave and 32-bit pairing
// Functional notes
// - Idle-stop set halts counting during idle; clear keeps counting in idle.
// - Gate-accumulate set counts prescaled internal ticks only while gate input is high.
// - Gate-accumulate clear counts every prescaled tick with no gating.
// - Prescale field bits 5:4 divide by 1, 8, 64, 256 for codes 00..11.
// - Unimplemented control bits 14, 12:7, 2, 0 read zero, writes ignored.
`timescale 1ns/1ps
`default_nettype none
module ptc_timer (
	input wire logic CORE_CLK,
	input wire logic RST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic IDLE,
	input wire logic GATE_IN,
	input wire logic EXTERNAL_COUNT_PIN
);
	import ptc_pkg::*;

	typedef struct packed {
		ptc_ctrl_t ctrl;
		logic partner_run;
		logic [15:0] low_half_count;
		logic [15:0] high_half_count;
		logic ext_q;
		logic wr_pend;
		logic [11:0] wr_addr;
		logic [31:0] rdata;
		logic readyout;
	} ptc_state_t;

	ptc_state_t s_r;
	ptc_state_t s_nxt;
	ptc_tick_if tk ();

	logic addr_phase;
	logic wr_now;
	logic wr_ctrl;
	logic wr_low;
	logic wr_high;
	logic run_ok;
	logic src_tick;
	logic gate_ok;
	logic low_wrap;

	// Unused size field: only whole-word transfers reach this slave
	logic unused_size;
	assign unused_size = ^HSIZE;

	// ***************************************************************
	// Helpers
	// ***************************************************************

	// Packs the control fields into their register positions
	function automatic logic [15:0] ctrl_word(input ptc_ctrl_t c);
		logic [15:0] w;
		w = 16'h0000;
		w[PTC_BIT_RUN] = c.run;
		w[PTC_BIT_IDLE_STOP] = c.idle_stop;
		w[PTC_BIT_GATE] = c.gate;
		w[PTC_BIT_PRESC_LO +: 2] = c.presc;
		w[PTC_BIT_WIDE] = c.wide;
		w[PTC_BIT_SRC] = c.src;
		ctrl_word = w & PTC_CTRL_WMASK;
	endfunction

	// True when a word address hits the given register
	function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] reg_addr);
		reg_hit = (a == reg_addr);
	endfunction

	// ***************************************************************
	// Bus decode
	// ***************************************************************

	// Writes land in the data phase; reads are answered from the post-write state
	assign addr_phase = HSEL && HREADY && (HTRANS == PTC_HTRANS_NONSEQ);
	assign wr_now = s_r.wr_pend;
	assign wr_ctrl = wr_now && reg_hit(s_r.wr_addr, PTC_ADDR_CTRL);
	assign wr_low = wr_now && reg_hit(s_r.wr_addr, PTC_ADDR_LOW);
	assign wr_high = wr_now && reg_hit(s_r.wr_addr, PTC_ADDR_HIGH);

	// ***************************************************************
	// Count enables
	// ***************************************************************

	// Idle halts counting only when idle-stop is set
	assign run_ok = s_r.ctrl.run && !(IDLE && s_r.ctrl.idle_stop);
	// Pin is synchronous to the core clock, so a single stage edge detect suffices
	assign src_tick = s_r.ctrl.src ? (EXTERNAL_COUNT_PIN && !s_r.ext_q) : 1'b1;
	// Gated mode relies on software keeping the internal source selected
	assign gate_ok = s_r.ctrl.gate ? GATE_IN : 1'b1;

	assign tk.tick_in = run_ok && src_tick && gate_ok;
	assign tk.code = s_r.ctrl.presc;
	// A control write restarts the prescaler so a new ratio starts from zero
	assign tk.clr = wr_ctrl;
	assign low_wrap = (s_r.low_half_count == PTC_COUNT_MAX);

	ptc_prescaler u_presc (
		.clk(CORE_CLK),
		.rst(RST),
		.tk(tk.presc)
	);

	// ***************************************************************
	// Next state
	// ***************************************************************
	always_comb begin
		logic [15:0] wd;
		wd = HWDATA[15:0];
		s_nxt = s_r;
		s_nxt.ext_q = EXTERNAL_COUNT_PIN;
		s_nxt.readyout = 1'b1;

		// Low half counts prescaled ticks
		if (tk.tick_out) begin
			s_nxt.low_half_count = s_r.low_half_count + 16'h0001;
		end

		// High half: carry in wide mode, else its own free run
		if (s_r.ctrl.wide) begin
			if (tk.tick_out && low_wrap) begin
				s_nxt.high_half_count = s_r.high_half_count + 16'h0001;
			end
		end else if (s_r.partner_run) begin
			s_nxt.high_half_count = s_r.high_half_count + 16'h0001;
		end

		// Software writes override counting in the same cycle
		if (wr_ctrl) begin
			s_nxt.ctrl.run = wd[PTC_BIT_RUN];
			s_nxt.ctrl.idle_stop = wd[PTC_BIT_IDLE_STOP];
			s_nxt.ctrl.gate = wd[PTC_BIT_GATE];
			s_nxt.ctrl.presc = ptc_presc_t'(wd[PTC_BIT_PRESC_LO +: 2]);
			s_nxt.ctrl.wide = wd[PTC_BIT_WIDE];
			s_nxt.ctrl.src = wd[PTC_BIT_SRC];
		end
		if (wr_now && reg_hit(s_r.wr_addr, PTC_ADDR_PARTNER)) begin
			s_nxt.partner_run = wd[PTC_BIT_PARTNER_RUN];
		end
		if (wr_low) begin
			s_nxt.low_half_count = wd;
		end
		if (wr_high) begin
			s_nxt.high_half_count = wd;
		end

		// Address phase capture
		// Writes outside the 4 KB register window are dropped, not aliased
		s_nxt.wr_pend = addr_phase && HWRITE && (HADDR[31:12] == 20'h00000);
		s_nxt.wr_addr = HADDR[11:0];
		if (addr_phase && !HWRITE) begin
			if (HADDR[31:12] != 20'h00000) begin
				s_nxt.rdata = 32'h0000_0000;
			end else if (reg_hit(HADDR[11:0], PTC_ADDR_CTRL)) begin
				s_nxt.rdata = {16'h0000, ctrl_word(s_nxt.ctrl)};
			end else if (reg_hit(HADDR[11:0], PTC_ADDR_LOW)) begin
				s_nxt.rdata = {16'h0000, s_nxt.low_half_count};
			end else if (reg_hit(HADDR[11:0], PTC_ADDR_HIGH)) begin
				s_nxt.rdata = {16'h0000, s_nxt.high_half_count};
			end else if (reg_hit(HADDR[11:0], PTC_ADDR_PARTNER)) begin
				s_nxt.rdata = {16'h0000, s_nxt.partner_run, 15'h0000};
			end else begin
				s_nxt.rdata = 32'h0000_0000;
			end
		end
	end

	// State register
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			s_r.ctrl <= ptc_ctrl_t'('0);
			s_r.partner_run <= 1'b0;
			s_r.low_half_count <= PTC_COUNT_RESET;
			s_r.high_half_count <= PTC_COUNT_RESET;
			s_r.ext_q <= 1'b0;
			s_r.wr_pend <= 1'b0;
			s_r.wr_addr <= 12'h000;
			s_r.rdata <= 32'h0000_0000;
			s_r.readyout <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// HRDATA and HREADYOUT straight from flops; HRESP tied low, so every response is OKAY
	assign HRDATA = s_r.rdata;
	assign HREADYOUT = s_r.readyout;
	assign HRESP = 1'b0;

	// ***************************************************************
	// Checks
	// ***************************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	chk_idle_stop_halt: assert property (
		(s_r.ctrl.run && s_r.ctrl.idle_stop && IDLE && !wr_now) |=>
		(s_r.low_half_count == $past(s_r.low_half_count)))
		else $error("low half moved while stopped in idle");
	chk_gate_low_hold: assert property (
		(s_r.ctrl.gate && !GATE_IN && !wr_now) |=>
		(s_r.low_half_count == $past(s_r.low_half_count)))
		else $error("gated count moved with gate low");
	chk_ungated_count: assert property (
		(s_r.ctrl.run && !s_r.ctrl.gate && !s_r.ctrl.src && !IDLE &&
		s_r.ctrl.presc == PTC_PRE_1 && !wr_now) |=>
		(s_r.low_half_count == $past(s_r.low_half_count) + 16'h0001))
		else $error("ungated divide by 1 did not count each cycle");
	chk_ctrl_reserved_zero: assert property (
		(addr_phase && !HWRITE && HADDR == {20'h00000, PTC_ADDR_CTRL}) |=>
		((HRDATA & ~{16'h0000, PTC_CTRL_WMASK}) == 32'h0000_0000))
		else $error("reserved control bits read nonzero");
	chk_wide_carry: assert property (
		(s_r.ctrl.wide && tk.tick_out && low_wrap && !wr_now) |=>
		(s_r.high_half_count == $past(s_r.high_half_count) + 16'h0001) &&
		(s_r.low_half_count == 16'h0000))
		else $error("32-bit carry into high half lost");
	chk_wide_no_carry: assert property (
		(s_r.ctrl.wide && !(tk.tick_out && low_wrap) && !wr_now) |=>
		(s_r.high_half_count == $past(s_r.high_half_count)))
		else $error("high half moved without a carry");
endmodule
`default_nettype wire

// ### test/test_pairable_timer_control.sv
// Testbench: register access and counting checks for the pairable timer
`timescale 1ns/1ps
`default_nettype none
module test_pairable_timer_control;
	import ptc_pkg::*;
	logic CORE_CLK, RST, HSEL, HWRITE, HREADY, HRESP, HREADYOUT, IDLE, GATE_IN, EXT_PIN;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0] HTRANS;
	logic [2:0] HSIZE;
	int n_mismatch = 0;
	int samples_checked = 0;
	localparam int SPAN = 256;

	// ***************************************************************
	// Clock, bus loop-back and a free-running external count pin
	// ***************************************************************
	initial begin
		CORE_CLK = 1'b0;
		forever #10 CORE_CLK = ~CORE_CLK;
	end
	assign HREADY = HREADYOUT;
	// Toggling every cycle gives one rising pin edge per two clocks
	initial begin
		EXT_PIN = 1'b0;
		forever @(posedge CORE_CLK) EXT_PIN <= ~EXT_PIN;
	end

	ptc_timer ptc_timer_inst (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .IDLE(IDLE),
		.GATE_IN(GATE_IN), .EXTERNAL_COUNT_PIN(EXT_PIN));

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	// One single AHB-Lite transfer; entered just after a rising edge
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		HSEL <= 1'b1;
		HADDR <= {20'h00000, a};
		HTRANS <= PTC_HTRANS_NONSEQ;
		HWRITE <= wr;
		HSIZE <= 3'h2;
		@(posedge CORE_CLK);
		while (HREADY !== 1'b1) @(posedge CORE_CLK);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		@(posedge CORE_CLK);
		while (HREADY !== 1'b1) @(posedge CORE_CLK);
		rd = HRDATA;
		chk({31'h00000000, HRESP}, 32'h00000000);
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, {16'h0000, d}, dummy);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
		logic [31:0] v;
		bus(1'b0, a, 32'h00000000, v);
		chk(v, {16'h0000, exp});
	endtask

	// Low count advance between two read address edges SPAN cycles apart
	task automatic meas(input logic [15:0] exp);
		logic [31:0] v0, v1;
		bus(1'b0, PTC_ADDR_LOW, 32'h00000000, v0);
		repeat (SPAN - 2) @(posedge CORE_CLK);
		bus(1'b0, PTC_ADDR_LOW, 32'h00000000, v1);
		chk({16'h0000, v1[15:0] - v0[15:0]}, {16'h0000, exp});
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ***************************************************************
	// Watchdog: the tests need a few thousand cycles
	// ***************************************************************
	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_mismatch++;
		summarize();
	end

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		RST = 1'b1;
		HSEL = 1'b0;
		HADDR = 32'h00000000;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HSIZE = 3'h2;
		HWDATA = 32'h00000000;
		IDLE = 1'b0;
		GATE_IN = 1'b0;
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		@(posedge CORE_CLK);
		rdchk(PTC_ADDR_CTRL, 16'h0000);
		rdchk(PTC_ADDR_LOW, 16'h0000);
		rdchk(PTC_ADDR_HIGH, 16'h0000);
		rdchk(PTC_ADDR_PARTNER, 16'h0000);
		// Unimplemented control bits drop writes; source kept internal with gate set
		wr(PTC_ADDR_CTRL, 16'hFFFD);
		rdchk(PTC_ADDR_CTRL, 16'hA078);
		wr(PTC_ADDR_CTRL, 16'h0000);
		wr(12'h010, 16'hFFFF);
		rdchk(12'h010, 16'h0000);
		wr(PTC_ADDR_PARTNER, 16'hFFFF);
		rdchk(PTC_ADDR_PARTNER, 16'h8000);
		wr(PTC_ADDR_PARTNER, 16'h0000);
		// Partner ran alone for the four cycles its run bit was set
		rdchk(PTC_ADDR_HIGH, 16'h0004);
		// Every prescale code, internal source; steady rate over SPAN cycles
		for (int c = 0; c < 4; c++) begin
			wr(PTC_ADDR_CTRL, 16'h8000 | (16'(c) << PTC_BIT_PRESC_LO));
			meas(16'(SPAN >> (3 * c - (c == 3 ? 1 : 0))));
		end
		// External source counts rising pin edges
		wr(PTC_ADDR_CTRL, 16'h8002);
		meas(16'(SPAN / 2));
		// Idle handling
		wr(PTC_ADDR_CTRL, 16'h8000);
		IDLE <= 1'b1;
		meas(16'(SPAN));
		wr(PTC_ADDR_CTRL, 16'hA000);
		meas(16'h0000);
		IDLE <= 1'b0;
		meas(16'(SPAN));
		// Gated accumulation keeps the internal source selected
		wr(PTC_ADDR_CTRL, 16'h8040);
		meas(16'h0000);
		GATE_IN <= 1'b1;
		meas(16'(SPAN));
		GATE_IN <= 1'b0;
		wr(PTC_ADDR_CTRL, 16'h8000);
		meas(16'(SPAN));
		// Pairing: a low wrap carries into the high half only in wide mode
		for (int w = 0; w < 2; w++) begin
			wr(PTC_ADDR_CTRL, 16'h0000);
			wr(PTC_ADDR_LOW, 16'hFFF0);
			wr(PTC_ADDR_HIGH, 16'h0005);
			wr(PTC_ADDR_CTRL, w ? 16'h8008 : 16'h8000);
			repeat (40) @(posedge CORE_CLK);
			wr(PTC_ADDR_CTRL, 16'h0000);
			rdchk(PTC_ADDR_HIGH, w ? 16'h0006 : 16'h0005);
		end
		summarize();
	end
endmodule
`default_nettype wire
